/* dps_pkg.sv */
// Purpose: constants and types for the semaphore-flag port controller
// Assumes: 20 MHz clk, one port of a dual-port part with eight flags
package dps_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int DATA_W        = 9;
    localparam int IDX_W         = 3;
    localparam int FLAG_COUNT    = 8;
    localparam int CNT_W         = 4;
    localparam int POLL_W        = 3;
    localparam int SYNC_STAGES   = 2;
    localparam int T_SETUP_NS    = 50;
    localparam int T_ACCESS_NS   = 100;
    localparam int T_RECOV_NS    = 50;
    localparam int MAX_POLLS     = 4;

    // least time to whole cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SETUP_CYC  = cyc_min(T_SETUP_NS);
    localparam int STROBE_CYC = cyc_min(T_ACCESS_NS) + SYNC_STAGES;
    localparam int RECOV_CYC  = cyc_min(T_RECOV_NS);

    localparam logic [CNT_W-1:0]  SETUP_CNT  = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0]  STROBE_CNT = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0]  RECOV_CNT  = CNT_W'(RECOV_CYC - 1);
    localparam logic [IDX_W-1:0]  LAST_INDEX = IDX_W'(FLAG_COUNT - 1);
    localparam logic [POLL_W-1:0] POLL_LAST  = POLL_W'(MAX_POLLS - 1);

    typedef enum logic [1:0] {
        OP_READ    = 2'h0,
        OP_CLAIM   = 2'h1,
        OP_RELEASE = 2'h2,
        OP_INIT    = 2'h3
    } dps_op_t;

    typedef struct packed {
        dps_op_t          op;
        logic [IDX_W-1:0] index;
    } dps_cmd_t;

    typedef struct packed {
        logic granted;
        logic flag;
    } dps_result_t;

    typedef struct packed {
        logic              selN;
        logic              rwN;
        logic              oeN;
        logic [IDX_W-1:0]  index;
        logic [DATA_W-1:0] dataOut;
        logic              dataOe;
    } dps_pins_t;

    localparam dps_pins_t PINS_IDLE = '{selN: 1'b1, rwN: 1'b1, oeN: 1'b1,
        index: 3'h0, dataOut: 9'h000, dataOe: 1'b0};

    typedef enum logic [1:0] {
        CY_IDLE   = 2'h0,
        CY_SETUP  = 2'h1,
        CY_STROBE = 2'h3,
        CY_RECOV  = 2'h2
    } dps_cyc_st_t;

    typedef struct packed {
        dps_cyc_st_t      st;
        logic [CNT_W-1:0] cnt;
        logic             isWrite;
        dps_pins_t        pins;
        logic             syncA;
        logic             syncB;
        logic             readBit;
        logic             done;
    } dps_cyc_state_t;

    localparam dps_cyc_state_t CYC_RESET = '{st: CY_IDLE, cnt: 4'h0,
        isWrite: 1'b0, pins: PINS_IDLE, syncA: 1'b1, syncB: 1'b1,
        readBit: 1'b1, done: 1'b0};

    typedef enum logic [2:0] {
        ST_INIT     = 3'h0,
        ST_IDLE     = 3'h1,
        ST_CLAIM    = 3'h3,
        ST_CHECK    = 3'h2,
        ST_WITHDRAW = 3'h6,
        ST_RELEASE  = 3'h7,
        ST_READ     = 3'h5
    } dps_ctl_st_t;

    typedef struct packed {
        dps_ctl_st_t       st;
        logic              issued;
        logic              start;
        logic              opWrite;
        logic              opBit;
        logic [IDX_W-1:0]  index;
        logic [POLL_W-1:0] polls;
        logic              cmdReady;
        logic              doneValid;
        dps_result_t       result;
    } dps_ctl_state_t;

    localparam dps_ctl_state_t CTL_RESET = '{st: ST_INIT, issued: 1'b0,
        start: 1'b0, opWrite: 1'b1, opBit: 1'b1, index: 3'h0, polls: 3'h0,
        cmdReady: 1'b0, doneValid: 1'b0,
        result: '{granted: 1'b0, flag: 1'b1}};

endpackage

/* dps_port_cycle.sv */
// Purpose: one flag-space access on the port pins, write or read
// Assumes: start only while idle; data pin input is asynchronous
// Notes:   select-controlled cycle: setup, strobe, recovery
`timescale 1ns/1ns
module dps_port_cycle
    import dps_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             start,
    input  wire logic             isWrite,
    input  wire logic             wrBit,
    input  wire logic [IDX_W-1:0] index,
    input  wire logic             dataBit,
    output dps_pins_t             pins,
    output logic                  readBit,
    output logic                  done
);

    dps_cyc_state_t q;
    dps_cyc_state_t d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        // flag shows on all bits, so bit zero alone is enough
        d.syncA = dataBit;
        d.syncB = q.syncA;
        case (q.st)
            CY_IDLE: begin
                if (start) begin
                    d.st = CY_SETUP;
                    d.cnt = SETUP_CNT;
                    d.isWrite = isWrite;
                    d.pins.index = index;
                    d.pins.dataOut = {DATA_W{wrBit}};
                    d.pins.rwN = ~isWrite;
                end
            end
            CY_SETUP: begin
                if (q.cnt == 4'h0) begin
                    d.st = CY_STROBE;
                    d.cnt = STROBE_CNT;
                    d.pins.selN = 1'b0;
                    d.pins.oeN = q.isWrite;
                    d.pins.dataOe = q.isWrite;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            CY_STROBE: begin
                if (q.cnt == 4'h0) begin
                    d.st = CY_RECOV;
                    d.cnt = RECOV_CNT;
                    d.pins.selN = 1'b1;
                    d.pins.oeN = 1'b1;
                    if (!q.isWrite) begin
                        d.readBit = q.syncB;
                    end
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            CY_RECOV: begin
                if (q.cnt == 4'h0) begin
                    d.st = CY_IDLE;
                    d.pins.rwN = 1'b1;
                    d.pins.dataOe = 1'b0;
                    d.done = 1'b1;
                end else begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default: begin
                d = CYC_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= CYC_RESET;
        end else begin
            q <= d;
        end
    end

    assign pins = q.pins;
    assign readBit = q.readBit;
    assign done = q.done;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_deselect_gap: assert property (
        $rose(q.pins.selN) |-> q.pins.selN [*2])
        else $error("select not held inactive between accesses");

    sequence seqReadOpen;
        $fell(q.pins.selN) && !q.pins.oeN;
    endsequence

    chk_read_window: assert property (
        seqReadOpen |-> (!q.pins.selN && !q.pins.oeN) [*4]
            ##1 (q.pins.selN && q.pins.oeN))
        else $error("read strobe length wrong");

    chk_write_drive: assert property (
        (!q.pins.selN && !q.pins.rwN) |-> (q.pins.dataOe && q.pins.oeN))
        else $error("write strobe without data drive");

endmodule

/* dps_flag_ctl.sv */
// Purpose: host controller for one port of an eight-flag semaphore unit
// Assumes: commands taken while cmdReady; one command at a time
// Notes:   frees all flags after reset before the first command
`timescale 1ns/1ns
module dps_flag_ctl
    import dps_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              cmdValid,
    input  dps_cmd_t               cmd,
    output logic                   cmdReady,
    output logic                   doneValid,
    output dps_result_t            result,
    output dps_pins_t              pins,
    input  wire logic [DATA_W-1:0] dataIn
);

    dps_ctl_state_t q;
    dps_ctl_state_t d;
    logic           engDone;
    logic           readBit;

    function automatic dps_ctl_state_t finish_op(input dps_ctl_state_t s,
                                                 input logic granted,
                                                 input logic flag);
        dps_ctl_state_t r;
        r = s;
        r.st = ST_IDLE;
        r.issued = 1'b0;
        r.cmdReady = 1'b1;
        r.doneValid = 1'b1;
        r.result.granted = granted;
        r.result.flag = flag;
        return r;
    endfunction

    dps_port_cycle u_cycle (
        .clk     (clk),
        .reset_n (reset_n),
        .start   (q.start),
        .isWrite (q.opWrite),
        .wrBit   (q.opBit),
        .index   (q.index),
        .dataBit (dataIn[0]),
        .pins    (pins),
        .readBit (readBit),
        .done    (engDone)
    );

    always_comb begin
        d = q;
        d.start = 1'b0;
        d.doneValid = 1'b0;
        if (q.st != ST_IDLE && !q.issued) begin
            d.start = 1'b1;
            d.issued = 1'b1;
        end
        case (q.st)
            ST_INIT: begin
                if (engDone) begin
                    d.issued = 1'b0;
                    if (q.index == LAST_INDEX) begin
                        d = finish_op(q, 1'b0, 1'b1);
                    end else begin
                        d.index = q.index + 1'b1;
                    end
                end
            end
            ST_IDLE: begin
                if (cmdValid) begin
                    d.cmdReady = 1'b0;
                    d.index = cmd.index;
                    d.polls = 3'h0;
                    d.opWrite = 1'b1;
                    d.opBit = 1'b1;
                    case (cmd.op)
                        OP_READ: begin
                            d.st = ST_READ;
                            d.opWrite = 1'b0;
                        end
                        OP_CLAIM: begin
                            d.st = ST_CLAIM;
                            d.opBit = 1'b0;
                        end
                        OP_RELEASE: begin
                            d.st = ST_RELEASE;
                        end
                        default: begin
                            d.st = ST_INIT;
                            d.index = 3'h0;
                        end
                    endcase
                end
            end
            ST_CLAIM: begin
                if (engDone) begin
                    d.issued = 1'b0;
                    d.st = ST_CHECK;
                    d.opWrite = 1'b0;
                end
            end
            ST_CHECK: begin
                if (engDone) begin
                    d.issued = 1'b0;
                    if (!readBit) begin
                        d = finish_op(q, 1'b1, 1'b0);
                    end else if (q.polls == POLL_LAST) begin
                        d.st = ST_WITHDRAW;
                        d.opWrite = 1'b1;
                        d.opBit = 1'b1;
                    end else begin
                        d.polls = q.polls + 1'b1;
                    end
                end
            end
            ST_WITHDRAW: begin
                if (engDone) begin
                    d = finish_op(q, 1'b0, 1'b1);
                end
            end
            ST_RELEASE: begin
                if (engDone) begin
                    d = finish_op(q, 1'b0, 1'b1);
                end
            end
            ST_READ: begin
                if (engDone) begin
                    d = finish_op(q, ~readBit, readBit);
                end
            end
            default: begin
                d = CTL_RESET;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= CTL_RESET;
        end else begin
            q <= d;
        end
    end

    assign cmdReady = q.cmdReady;
    assign doneValid = q.doneValid;
    assign result = q.result;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence seqClaimWritten;
        q.st == ST_CLAIM && engDone;
    endsequence

    sequence seqReadIssued;
        q.start && !q.opWrite;
    endsequence

    sequence seqLastPollFailed;
        q.st == ST_CHECK && engDone && readBit && q.polls == POLL_LAST;
    endsequence

    chk_claim_then_read: assert property (
        seqClaimWritten |=> q.st == ST_CHECK ##1 seqReadIssued)
        else $error("claim write not followed by read back");

    chk_claim_zero: assert property (
        q.st == ST_CLAIM |-> (q.opWrite && !q.opBit))
        else $error("claim does not write zero");

    chk_fail_withdraw: assert property (
        seqLastPollFailed |=> (q.st == ST_WITHDRAW && q.opWrite && q.opBit)
            ##1 q.start)
        else $error("failed claim not withdrawn with a one");

    chk_poll_again: assert property (
        (q.st == ST_CHECK && engDone && readBit && q.polls != POLL_LAST)
            |=> q.st == ST_CHECK ##1 seqReadIssued)
        else $error("failed claim not read again");

    chk_init_ones: assert property (
        q.st == ST_INIT |-> (q.opWrite && q.opBit))
        else $error("init writes something other than one");

    chk_init_all: assert property (
        (q.st == ST_INIT && engDone && q.index == LAST_INDEX)
            |=> (q.st == ST_IDLE && q.cmdReady && q.doneValid))
        else $error("init did not end after the last flag");

    chk_grant_zero: assert property (
        (q.st == ST_CHECK && engDone && !readBit)
            |=> (doneValid && result.granted && !result.flag))
        else $error("zero read back not reported as grant");

    chk_release_one: assert property (
        q.st == ST_RELEASE |-> (q.opWrite && q.opBit))
        else $error("release does not write one");

    chk_check_reads: assert property (
        q.st == ST_CHECK |-> !q.opWrite)
        else $error("read back is not a read");

    chk_withdraw_result: assert property (
        (q.st == ST_WITHDRAW && engDone)
            |=> (doneValid && !result.granted && result.flag))
        else $error("withdrawn claim not reported as failed");

    chk_init_step: assert property (
        (q.st == ST_INIT && engDone && q.index != LAST_INDEX)
            |=> (q.st == ST_INIT && q.index == $past(q.index) + 1'b1))
        else $error("init skipped a flag");

endmodule

/* dps_sem_model.sv */
// Purpose: behavioural flag unit facing the port controller
// Assumes: near port on controller pins, far port as a clocked strobe
// Notes:   near side owns every flag at start to expose a missing init
`timescale 1ns/1ns
module dps_sem_model
    import dps_pkg::*;
(
    input  wire logic                 clk,
    input  dps_pins_t                 pins,
    output logic [DATA_W-1:0]         dataIn,
    input  wire logic                 farWrite,
    input  wire logic [IDX_W-1:0]     farIndex,
    input  wire logic                 farBit,
    output logic [FLAG_COUNT-1:0]     farView
);
    logic [FLAG_COUNT-1:0] reqNearN;
    logic [FLAG_COUNT-1:0] reqFarN;
    logic [FLAG_COUNT-1:0] ownNear;
    logic [FLAG_COUNT-1:0] ownFar;
    logic                  rdVal;
    wire logic             selNearN = pins.selN;
    wire logic             rdAct = !pins.selN && !pins.oeN && pins.rwN;

    task automatic put(input logic near, input logic [IDX_W-1:0] i,
                       input logic b);
        if (near) begin
            reqNearN[i] = b;
            if (!b && !ownFar[i]) ownNear[i] = 1'b1;
            if (b && ownNear[i]) begin
                ownNear[i] = 1'b0;
                ownFar[i] = !reqFarN[i];
            end
        end else begin
            reqFarN[i] = b;
            if (!b && !ownNear[i]) ownFar[i] = 1'b1;
            if (b && ownFar[i]) begin
                ownFar[i] = 1'b0;
                ownNear[i] = !reqNearN[i];
            end
        end
    endtask

    initial begin
        reqNearN = '0;
        ownNear = '1;
        reqFarN = '1;
        ownFar = '0;
        rdVal = 1'b0;
    end

    // far strobe wins a same-step tie
    always @(posedge clk) begin
        if (farWrite) put(1'b0, farIndex, farBit);
    end

    // write ends as select rises; no ram
    always @(posedge selNearN) begin
        if (!pins.rwN) put(1'b1, pins.index, pins.dataOut[0]);
    end

    // flag captured as the read opens
    always @(posedge rdAct) begin
        rdVal = !ownNear[pins.index];
    end

    // flag on every bit; released bus shows inverse
    assign dataIn = pins.dataOe ? pins.dataOut
                  : (rdAct ? {DATA_W{rdVal}} : {DATA_W{!rdVal}});
    assign farView = ~ownFar;
endmodule

/* dps_flag_ctl_bench.sv */
// Purpose: self-checking bench for the flag port controller
// Assumes: far port of the flag unit driven by the bench
// Notes:   results noted in a queue and checked by a watcher process
`timescale 1ns/1ns
module dps_flag_ctl_bench
    import dps_pkg::*;
;
    localparam int DLY  = 5;
    localparam int CEIL = 20000;

    typedef struct packed {
        logic        chk;
        dps_result_t r;
    } dps_note_t;

    logic                  clk;
    logic                  reset_n;
    logic                  cmdValid;
    dps_cmd_t              cmd;
    logic                  cmdReady;
    logic                  doneValid;
    dps_result_t           result;
    dps_pins_t             pins;
    logic [DATA_W-1:0]     dataIn;
    logic                  farWrite;
    logic [IDX_W-1:0]      farIndex;
    logic                  farBit;
    logic [FLAG_COUNT-1:0] farView;
    logic [FLAG_COUNT-1:0] ownL;
    logic [FLAG_COUNT-1:0] ownF;
    logic [FLAG_COUNT-1:0] reqFN;
    logic [31:0]           seed;
    int                    nMismatch;
    int                    nCompared;
    int                    cycles;
    dps_note_t             notes[$];

    dps_flag_ctl dps_flag_ctl_i (.clk(clk), .reset_n(reset_n),
        .cmdValid(cmdValid), .cmd(cmd), .cmdReady(cmdReady),
        .doneValid(doneValid), .result(result), .pins(pins),
        .dataIn(dataIn));
    dps_sem_model dps_sem_model_i (.clk(clk), .pins(pins), .dataIn(dataIn),
        .farWrite(farWrite), .farIndex(farIndex), .farBit(farBit),
        .farView(farView));

    always #25 clk = !clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        nCompared++;
        if (seen !== exp) begin
            nMismatch++;
            $display("ERROR %0t %s: seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic do_cmd(input dps_op_t op, input logic [IDX_W-1:0] idx,
                          input logic chk, input dps_result_t r,
                          input int lat);
        int k;
        @(posedge clk);
        #DLY;
        cmdValid = 1'b1;
        cmd = '{op: op, index: idx};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (cmdReady !== 1'b1 && k < 200);
        notes.push_back('{chk: chk, r: r});
        #DLY;
        cmdValid = 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (doneValid !== 1'b1 && k < 100);
        if (lat != 0) check(k, lat, "latency");
    endtask

    task automatic far_write(input logic [IDX_W-1:0] idx, input logic b);
        @(posedge clk);
        #DLY;
        farWrite = 1'b1;
        farIndex = idx;
        farBit = b;
        @(posedge clk);
        #DLY;
        farWrite = 1'b0;
    endtask

    // watcher: oldest note against each finished command
    always @(posedge clk) begin
        if (doneValid === 1'b1) begin
            if (notes.size() == 0) begin
                check(1, 0, "unexpected done");
            end else if (notes[0].chk) begin
                check(result, notes[0].r, "result");
            end
            if (notes.size() != 0) void'(notes.pop_front());
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == CEIL) begin
            check(0, 1, "timeout");
            end_of_test();
        end
    end

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        cmdValid = 1'b0;
        cmd = '0;
        farWrite = 1'b0;
        farIndex = '0;
        farBit = 1'b1;
        seed = 32'h3fa6b888;
        nMismatch = 0;
        nCompared = 0;
        cycles = 0;
        repeat (3) @(posedge clk);
        #1;
        check(pins, PINS_IDLE, "pins in reset");
        check(cmdReady, 0, "ready in reset");
        notes.push_back('{chk: 1'b1, r: '{granted: 1'b0, flag: 1'b1}});
        repeat (2) @(posedge clk);
        #DLY;
        reset_n = 1'b1;
        repeat (60) @(posedge clk);
        for (int i = 0; i < FLAG_COUNT; i++) begin
            far_write(i[IDX_W-1:0], 1'b0);
            check(farView[i], 0, "far claim after init");
            far_write(i[IDX_W-1:0], 1'b1);
        end
        $display("test init done");
        for (int i = 0; i < FLAG_COUNT; i++) begin
            do_cmd(OP_CLAIM, i[IDX_W-1:0], 1'b1, 2'b10, 18);
            check(farView[i], 1, "far view of claim");
            do_cmd(OP_READ, i[IDX_W-1:0], 1'b1, 2'b10, 9);
        end
        $display("test claim all done");
        far_write(3'h3, 1'b0);
        check(farView[3], 1, "far blocked");
        do_cmd(OP_RELEASE, 3'h3, 1'b1, 2'b01, 9);
        check(farView[3], 0, "pending far takes");
        do_cmd(OP_CLAIM, 3'h3, 1'b1, 2'b01, 54);
        far_write(3'h3, 1'b1);
        check(farView[3], 1, "withdrawn request");
        do_cmd(OP_READ, 3'h3, 1'b1, 2'b01, 9);
        $display("test contention done");
        do_cmd(OP_INIT, 3'h0, 1'b1, 2'b01, 72);
        for (int i = 0; i < FLAG_COUNT; i++) far_write(i[IDX_W-1:0], 1'b0);
        check(farView, 0, "init frees all");
        for (int i = 0; i < FLAG_COUNT; i++) far_write(i[IDX_W-1:0], 1'b1);
        $display("test init command done");
        ownL = '0;
        ownF = '0;
        reqFN = '1;
        for (int n = 0; n < 40; n++) begin
            seed = lfsr(seed);
            case (seed[1:0])
                2'h0: do_cmd(OP_READ, seed[4:2], 1'b1,
                             {ownL[seed[4:2]], !ownL[seed[4:2]]}, 9);
                2'h1: begin
                    do_cmd(OP_CLAIM, seed[4:2], 1'b1,
                           {!ownF[seed[4:2]], ownF[seed[4:2]]},
                           ownF[seed[4:2]] ? 54 : 18);
                    if (!ownF[seed[4:2]]) ownL[seed[4:2]] = 1'b1;
                end
                2'h2: begin
                    do_cmd(OP_RELEASE, seed[4:2], 1'b1, 2'b01, 9);
                    if (ownL[seed[4:2]] && !reqFN[seed[4:2]])
                        ownF[seed[4:2]] = 1'b1;
                    ownL[seed[4:2]] = 1'b0;
                end
                default: begin
                    far_write(seed[4:2], seed[5]);
                    reqFN[seed[4:2]] = seed[5];
                    if (seed[5]) ownF[seed[4:2]] = 1'b0;
                    else if (!ownL[seed[4:2]]) ownF[seed[4:2]] = 1'b1;
                end
            endcase
            check(farView, FLAG_COUNT'(~ownF), "far view");
        end
        // let the watcher take the last note first
        repeat (2) @(posedge clk);
        #1;
        check(notes.size(), 0, "notes left");
        $display("test random done");
        end_of_test();
    end
endmodule
